// ---- logic/cskip_io_pkg.sv ----
package cskip_io_pkg;

  // ==========================================================================
  // word and instruction layout
  localparam int unsigned WORD_W = 24;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned OPC_W = 6;
  localparam int unsigned OPC_LSB = 18;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned SEL_LSB = 15;
  localparam int unsigned CHAR_W = 7;
  localparam int unsigned SIX_W = 6;
  localparam int unsigned THIRD_W = 8;
  localparam int unsigned LOW_FIELD_W = 15;
  localparam logic [2:0] CHARS_PER_WORD = 3'h4;

  // ==========================================================================
  // operation codes (octal 64..67, 70..72)
  localparam logic [OPC_W-1:0] OP_EQUAL_SKIP = 6'h34;
  localparam logic [OPC_W-1:0] OP_UNEQUAL_SKIP = 6'h35;
  localparam logic [OPC_W-1:0] OP_GREATER_SKIP = 6'h36;
  localparam logic [OPC_W-1:0] OP_LESS_SKIP = 6'h37;
  localparam logic [OPC_W-1:0] OP_EXTERNAL_FUNCTION = 6'h38;
  localparam logic [OPC_W-1:0] OP_READ_FROM_DEVICE = 6'h39;
  localparam logic [OPC_W-1:0] OP_WRITE_TO_DEVICE = 6'h3a;

  // portion selectors that assemble whole words through the shift register
  localparam logic [SEL_W-1:0] SEL_WORD = 3'h0;
  localparam logic [SEL_W-1:0] SEL_LOW15 = 3'h4;

  // ==========================================================================
  // timing, in microseconds, and the clock rate
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned T_EQ_US = 64;
  localparam int unsigned T_EQ_RPT_US = 44;
  localparam int unsigned T_GT_US = 60;
  localparam int unsigned T_GT_RPT_US = 40;
  localparam int unsigned T_EXF_US = 36;
  localparam int unsigned T_EXF_RPT_US = 16;
  localparam int unsigned T_RD_US = 52;
  localparam int unsigned T_RD_RPT_US = 32;
  localparam int unsigned T_RDA_US = 120;
  localparam int unsigned T_RDA_RPT_US = 100;
  localparam int unsigned T_WR_US = 40;
  localparam int unsigned T_WR_RPT_US = 20;
  localparam int unsigned T_WRA_US = 116;
  localparam int unsigned T_WRA_RPT_US = 96;
  localparam int unsigned CYC_EXF_RPT = T_EXF_RPT_US * CLK_MHZ;

  localparam int unsigned TMR_W = 16;
  typedef logic [TMR_W-1:0] cyc_t;

  // ==========================================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_FETCH = 4'b0001,
    ST_EVAL = 4'b0010,
    ST_RX_WAIT = 4'b0011,
    ST_RX_DROP = 4'b0100,
    ST_TX_WAIT = 4'b0101,
    ST_TX_DROP = 4'b0110,
    ST_EXF_WAIT = 4'b0111,
    ST_STORE = 4'b1000,
    ST_HOLD = 4'b1001,
    ST_FAULT = 4'b1010
  } seq_state_e;

endpackage : cskip_io_pkg

// ---- logic/min_timer_if.sv ----
`timescale 1ns/1ps
interface min_timer_if;
  logic load;
  cskip_io_pkg::cyc_t cycles;
  logic expired;
  modport ctl (output load, output cycles, input expired);
  modport tmr (input load, input cycles, output expired);
endinterface : min_timer_if

// ---- logic/min_timer.sv ----
`timescale 1ns/1ps
module min_timer import cskip_io_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  min_timer_if.tmr tif
);

  // ==========================================================================
  // least operation time counter
  cyc_t cnt_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      cnt_q <= '0;
    end else if (tif.load) begin
      cnt_q <= cyc_t'(tif.cycles - cyc_t'(1));
    end else if (cnt_q != '0) begin
      cnt_q <= cyc_t'(cnt_q - cyc_t'(1));
    end
  end

  // not expired in the load cycle itself, so a fresh start never slips through
  assign tif.expired = (cnt_q == '0) && !tif.load;

endmodule : min_timer

// ---- logic/cskip_io_exec.sv ----
// Operation
// (RL1) equal_skip: skip next instruction when accumulator equals operand
// (RL2) unequal_skip: skip next instruction when accumulator differs from operand
// (RL3) greater_skip: skip when accumulator is greater than or equal to operand
// (RL4) less_skip: skip when accumulator is strictly below operand
// (RL5) compare operations never change the accumulator
// (RL6) operand address is low fifteen instruction bits plus index
// (RL7) repeated compare stops repeating once the skip condition holds
// (RL8) portion selector picks the compared part of the word
// (RL9) equal/unequal 64 us, repeat 44; greater/less 60 us, repeat 40
// (RL10) external_function loads command register with address and starts function
// (RL11) peripherals decode the fifteen-bit command; selector is meaningless
// (RL12) after an illegal command the next external_function waits forever
// (RL13) external_function takes 36 us, repeat 16
// (RL14) read selector 0 assembles four six-bit characters then stores word
// (RL15) read single selectors put seven-bit character into selected third
// (RL16) read selector 4 assembles like 0 but stores only low fifteen bits
// (RL17) disconnect during assembly leaves the storage word unchanged
// (RL18) read least 52 us, repeat 32; assembling 120, repeat 100
// (RL19) read or write under single stepping raises an io fault
// (RL20) write selector 0 rotates six, emits low six bits, four times
// (RL21) write single selectors emit low seven bits of selected section
// (RL22) write selector 4 loads only low fifteen bits, then emits as 0
// (RL23) taken skip advances program counter by two, else by one
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module cskip_io_exec import cskip_io_pkg::*; #(
  parameter int unsigned EQ_CYC = T_EQ_US * CLK_MHZ,
  parameter int unsigned EQ_RPT_CYC = T_EQ_RPT_US * CLK_MHZ,
  parameter int unsigned GT_CYC = T_GT_US * CLK_MHZ,
  parameter int unsigned GT_RPT_CYC = T_GT_RPT_US * CLK_MHZ,
  parameter int unsigned EXF_CYC = T_EXF_US * CLK_MHZ,
  parameter int unsigned RD_CYC = T_RD_US * CLK_MHZ,
  parameter int unsigned RD_RPT_CYC = T_RD_RPT_US * CLK_MHZ,
  parameter int unsigned RDA_CYC = T_RDA_US * CLK_MHZ,
  parameter int unsigned RDA_RPT_CYC = T_RDA_RPT_US * CLK_MHZ,
  parameter int unsigned WR_CYC = T_WR_US * CLK_MHZ,
  parameter int unsigned WR_RPT_CYC = T_WR_RPT_US * CLK_MHZ,
  parameter int unsigned WRA_CYC = T_WRA_US * CLK_MHZ,
  parameter int unsigned WRA_RPT_CYC = T_WRA_RPT_US * CLK_MHZ
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire logic [WORD_W-1:0] i_instr,
  input wire logic [ADDR_W-1:0] i_index_val,
  input wire logic [WORD_W-1:0] i_acc,
  input wire logic i_repeat,
  input wire logic i_step_mode,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [WORD_W-1:0] o_mem_wdata,
  input wire logic [WORD_W-1:0] i_mem_rdata,
  output logic [ADDR_W-1:0] o_ext_cmd,
  output logic o_ext_start,
  input wire logic i_ext_free,
  input wire logic [CHAR_W-1:0] i_rx_char,
  input wire logic i_rx_full,
  output logic o_rx_take,
  input wire logic i_disconnect,
  output logic [CHAR_W-1:0] o_tx_char,
  output logic o_tx_start,
  input wire logic i_tx_free,
  output logic o_busy,
  output logic o_done,
  output logic o_skip,
  output logic [1:0] o_pc_step,
  output logic o_repeat_stop,
  output logic o_io_fault
);

  // ==========================================================================
  // helpers
  function automatic logic [4:0] third_lsb(input logic [SEL_W-1:0] sel);
    logic [1:0] t;
    t = sel[1:0] - 2'h1;
    return {t, 3'h0};
  endfunction : third_lsb

  function automatic logic [WORD_W-1:0] portion_mask(input logic [SEL_W-1:0] sel);
    logic [WORD_W-1:0] m;
    m = {{(WORD_W-THIRD_W){1'b0}}, {THIRD_W{1'b1}}} << third_lsb(sel);
    if (sel == SEL_WORD) m = '1;
    if (sel == SEL_LOW15) m = {{(WORD_W-LOW_FIELD_W){1'b0}}, {LOW_FIELD_W{1'b1}}};
    return m;
  endfunction : portion_mask

  function automatic logic [CHAR_W-1:0] get7(input logic [WORD_W-1:0] w, input logic [SEL_W-1:0] sel);
    return w[third_lsb(sel) +: CHAR_W];
  endfunction : get7

  function automatic logic [WORD_W-1:0] rotl6(input logic [WORD_W-1:0] w);
    return {w[WORD_W-SIX_W-1:0], w[WORD_W-1 -: SIX_W]};
  endfunction : rotl6

  // ==========================================================================
  // pin synchronisers
  localparam int unsigned SYNC_W = CHAR_W + 4;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [CHAR_W-1:0] rx_char_s;
  logic rx_full_s;
  logic tx_free_s;
  logic ext_free_s;
  logic disc_s;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {i_rx_char, i_rx_full, i_tx_free, i_ext_free, i_disconnect};
      sync2_q <= sync1_q;
    end
  end
  assign {rx_char_s, rx_full_s, tx_free_s, ext_free_s, disc_s} = sync2_q;

  // ==========================================================================
  // decode of the current instruction
  seq_state_e state_q;
  seq_state_e state_d;
  logic [OPC_W-1:0] op_q;
  logic [SEL_W-1:0] sel_q;
  logic [ADDR_W-1:0] addr_q;
  logic rpt_q;
  logic [WORD_W-1:0] word_q;
  logic [WORD_W-1:0] aux_q;
  logic [2:0] nchar_q;
  logic [CHAR_W-1:0] rxc_q;
  logic aborted_q;
  logic skip_q;
  logic fault_q;

  logic [OPC_W-1:0] opc_in;
  logic [SEL_W-1:0] sel_in;
  logic is_cmp_in;
  logic is_io_in;
  logic known_in;
  logic asm_q;
  logic is_rd_q;
  logic [WORD_W-1:0] acc_m;
  logic [WORD_W-1:0] opd_m;
  logic cmp_hit;

  assign opc_in = i_instr[OPC_LSB +: OPC_W];
  assign sel_in = i_instr[SEL_LSB +: SEL_W];
  assign is_cmp_in = (opc_in[OPC_W-1:2] == OP_EQUAL_SKIP[OPC_W-1:2]);
  assign is_io_in = (opc_in == OP_READ_FROM_DEVICE) || (opc_in == OP_WRITE_TO_DEVICE);
  assign known_in = is_cmp_in || is_io_in || (opc_in == OP_EXTERNAL_FUNCTION);
  assign asm_q = (sel_q[1:0] == 2'h0);
  assign is_rd_q = (op_q == OP_READ_FROM_DEVICE);

  // accumulator is only sampled, never written back (see RL5)
  assign acc_m = i_acc & portion_mask(sel_q); // see RL8
  assign opd_m = i_mem_rdata & portion_mask(sel_q);

  always_comb begin
    case (op_q)
      OP_EQUAL_SKIP: cmp_hit = (acc_m == opd_m); // see RL1
      OP_UNEQUAL_SKIP: cmp_hit = (acc_m != opd_m); // see RL2
      OP_GREATER_SKIP: cmp_hit = (acc_m >= opd_m); // see RL3
      OP_LESS_SKIP: cmp_hit = (acc_m < opd_m); // see RL4
      default: cmp_hit = 1'b0;
    endcase
  end

  // ==========================================================================
  // least operation time
  min_timer_if tif();
  min_timer u_tmr (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .tif(tif)
  );

  assign tif.load = (state_q == ST_IDLE) && i_start && known_in;

  always_comb begin
    case (opc_in)
      OP_EQUAL_SKIP, OP_UNEQUAL_SKIP: tif.cycles = cyc_t'(i_repeat ? EQ_RPT_CYC : EQ_CYC); // see RL9
      OP_GREATER_SKIP, OP_LESS_SKIP: tif.cycles = cyc_t'(i_repeat ? GT_RPT_CYC : GT_CYC); // see RL9
      OP_EXTERNAL_FUNCTION: tif.cycles = cyc_t'(i_repeat ? CYC_EXF_RPT : EXF_CYC); // see RL13
      OP_READ_FROM_DEVICE: begin
        if (sel_in[1:0] == 2'h0) begin
          tif.cycles = cyc_t'(i_repeat ? RDA_RPT_CYC : RDA_CYC); // see RL18
        end else begin
          tif.cycles = cyc_t'(i_repeat ? RD_RPT_CYC : RD_CYC); // see RL18
        end
      end
      OP_WRITE_TO_DEVICE: begin
        if (sel_in[1:0] == 2'h0) begin
          tif.cycles = cyc_t'(i_repeat ? WRA_RPT_CYC : WRA_CYC);
        end else begin
          tif.cycles = cyc_t'(i_repeat ? WR_RPT_CYC : WR_CYC);
        end
      end
      default: tif.cycles = cyc_t'(1);
    endcase
  end

  // ==========================================================================
  // sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (i_start && known_in) begin
          if (opc_in == OP_EXTERNAL_FUNCTION) begin
            state_d = ST_EXF_WAIT;
          end else if (is_io_in && i_step_mode) begin
            state_d = ST_FAULT; // see RL19
          end else begin
            state_d = ST_FETCH;
          end
        end
      end
      ST_FETCH: state_d = ST_EVAL;
      ST_EVAL: begin
        if (!is_rd_q && op_q != OP_WRITE_TO_DEVICE) begin
          state_d = ST_HOLD;
        end else begin
          state_d = is_rd_q ? ST_RX_WAIT : ST_TX_WAIT;
        end
      end
      ST_RX_WAIT: begin
        if (disc_s) begin
          state_d = ST_HOLD; // see RL17
        end else if (rx_full_s) begin
          state_d = ST_RX_DROP;
        end
      end
      ST_RX_DROP: begin
        if (disc_s && nchar_q != 3'h0) begin
          state_d = ST_HOLD; // see RL17
        end else if (!rx_full_s) begin
          state_d = (nchar_q == 3'h0) ? ST_STORE : ST_RX_WAIT;
        end
      end
      ST_TX_WAIT: if (tx_free_s) state_d = ST_TX_DROP;
      ST_TX_DROP: begin
        if (!tx_free_s) begin
          state_d = (nchar_q == 3'h0) ? ST_HOLD : ST_TX_WAIT;
        end
      end
      // an illegal earlier command keeps the peripheral busy: stall here
      ST_EXF_WAIT: if (ext_free_s) state_d = ST_HOLD; // see RL12
      ST_STORE: state_d = ST_HOLD;
      ST_HOLD: if (tif.expired) state_d = ST_IDLE;
      ST_FAULT: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // operand, shift register and character data
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      op_q <= '0;
      sel_q <= '0;
      addr_q <= '0;
      rpt_q <= 1'b0;
      word_q <= '0;
      aux_q <= '0;
      nchar_q <= '0;
      rxc_q <= '0;
      aborted_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (i_start) begin
            op_q <= opc_in;
            sel_q <= sel_in;
            addr_q <= ADDR_W'(i_instr[ADDR_W-1:0] + i_index_val); // see RL6
            rpt_q <= i_repeat;
            aborted_q <= 1'b0;
            skip_q <= 1'b0;
          end
        end
        ST_EVAL: begin
          word_q <= i_mem_rdata;
          skip_q <= cmp_hit;
          nchar_q <= asm_q ? CHARS_PER_WORD : 3'h1;
          if (is_rd_q) begin
            aux_q <= '0; // see RL14
          end else if (sel_q == SEL_LOW15) begin
            aux_q <= {{(WORD_W-LOW_FIELD_W){1'b0}}, i_mem_rdata[LOW_FIELD_W-1:0]}; // see RL22
          end else begin
            aux_q <= i_mem_rdata; // see RL20
          end
        end
        ST_RX_WAIT: begin
          if (disc_s) begin
            aborted_q <= 1'b1;
          end else if (rx_full_s) begin
            rxc_q <= rx_char_s;
            nchar_q <= nchar_q - 3'h1;
            aux_q <= {aux_q[WORD_W-SIX_W-1:0], rx_char_s[SIX_W-1:0]}; // see RL14
          end
        end
        ST_RX_DROP: if (disc_s && nchar_q != 3'h0) aborted_q <= 1'b1;
        ST_TX_WAIT: begin
          if (tx_free_s) begin
            nchar_q <= nchar_q - 3'h1;
            if (asm_q) aux_q <= rotl6(aux_q); // see RL20
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // storage and peripheral strobes
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_mem_addr <= '0;
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_wdata <= '0;
      o_ext_cmd <= '0;
      o_ext_start <= 1'b0;
      o_rx_take <= 1'b0;
      o_tx_char <= '0;
      o_tx_start <= 1'b0;
    end else begin
      o_mem_rd <= (state_d == ST_FETCH);
      o_mem_wr <= (state_q == ST_STORE);
      o_ext_start <= 1'b0;
      o_rx_take <= (state_q == ST_RX_WAIT) && rx_full_s && !disc_s;
      o_tx_start <= 1'b0;
      if (state_q == ST_IDLE && i_start) begin
        o_mem_addr <= ADDR_W'(i_instr[ADDR_W-1:0] + i_index_val); // see RL6
      end
      if (state_q == ST_EXF_WAIT && ext_free_s) begin
        o_ext_cmd <= addr_q; // see RL10
        o_ext_start <= 1'b1; // see RL10
      end
      if (state_q == ST_STORE) begin
        if (!asm_q) begin
          o_mem_wdata <= word_q;
          o_mem_wdata[third_lsb(sel_q) +: CHAR_W] <= rxc_q; // see RL15
        end else if (sel_q == SEL_LOW15) begin
          o_mem_wdata <= {word_q[WORD_W-1:LOW_FIELD_W], aux_q[LOW_FIELD_W-1:0]}; // see RL16
        end else begin
          o_mem_wdata <= aux_q; // see RL14
        end
      end
      if (state_q == ST_TX_WAIT && tx_free_s) begin
        o_tx_start <= 1'b1;
        if (asm_q) begin
          o_tx_char <= {1'b0, aux_q[WORD_W-1 -: SIX_W]}; // see RL20
        end else begin
          o_tx_char <= get7(word_q, sel_q); // see RL21
        end
      end
    end
  end

  // ==========================================================================
  // completion report
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_done <= 1'b0;
      o_skip <= 1'b0;
      o_pc_step <= 2'h1;
      o_repeat_stop <= 1'b0;
      o_io_fault <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      o_done <= (state_q == ST_HOLD && tif.expired) || (state_q == ST_FAULT);
      o_io_fault <= (state_q == ST_FAULT); // see RL19
      fault_q <= (state_q == ST_FAULT);
      if (state_q == ST_HOLD && tif.expired) begin
        o_skip <= skip_q;
        o_pc_step <= skip_q ? 2'h2 : 2'h1; // see RL23
        o_repeat_stop <= rpt_q && skip_q; // see RL7
      end else if (state_q == ST_FAULT) begin
        o_skip <= 1'b0;
        o_pc_step <= 2'h1;
        o_repeat_stop <= 1'b0;
      end
    end
  end

  assign o_busy = (state_q != ST_IDLE);

  // ==========================================================================
  // checks
  chk_skip_pc: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RL23
    o_done |-> (o_pc_step == (o_skip ? 2'h2 : 2'h1))) else $error("pc step does not match skip");
  chk_repeat_stop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RL7
    o_done && o_repeat_stop |-> o_skip) else $error("repeat stopped without skip");
  chk_ext_cmd: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RL10
    o_ext_start |-> (o_ext_cmd == addr_q) && $past(ext_free_s)) else $error("bad external command");
  chk_ext_stall: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RL12
    state_q == ST_EXF_WAIT && !ext_free_s |=> state_q == ST_EXF_WAIT) else $error("left stall early");
  chk_addr_index: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RL6
    state_q == ST_IDLE && i_start && known_in |=> o_mem_addr == $past(i_instr[ADDR_W-1:0] + i_index_val))
    else $error("operand address not indexed");
  chk_least_time: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RL9
    o_done && !fault_q |-> $past(tif.expired)) else $error("done before least time");
  chk_asm_count: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RL14
    o_mem_wr && is_rd_q && asm_q |-> nchar_q == 3'h0) else $error("store before four characters");
  chk_disc_nostore: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RL17
    state_q == ST_RX_WAIT && disc_s |=> !o_mem_wr [*2]) else $error("store after disconnect");
  chk_low15_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RL16
    o_mem_wr && is_rd_q && sel_q == SEL_LOW15 |-> o_mem_wdata[WORD_W-1:LOW_FIELD_W] == word_q[WORD_W-1:LOW_FIELD_W])
    else $error("upper bits overwritten");
  chk_tx_single: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RL21
    o_tx_start && !asm_q |-> o_tx_char == get7(word_q, sel_q)) else $error("wrong single character");
  chk_step_fault: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see RL19
    state_q == ST_IDLE && i_start && is_io_in && i_step_mode |=> ##1 o_io_fault && o_done)
    else $error("no io fault under stepping");

  cov_skip_taken: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) o_done && o_skip);
  cov_ext_start: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) o_ext_start);
  cov_asm_store: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) o_mem_wr && is_rd_q && asm_q);
  cov_disconnect: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) o_done && aborted_q);

endmodule : cskip_io_exec

// ---- tb/periph_model.sv ----
`timescale 1ns/1ps
// ==========================================
// peripheral: command, input and output sides
module periph_model import cskip_io_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_hang,
  input wire logic i_rx_take,
  input wire logic i_tx_start,
  output logic o_ext_free,
  output logic o_rx_full,
  output logic [CHAR_W-1:0] o_rx_char,
  output logic o_tx_free
);
  logic [5:0] n_q;
  logic [2:0] rg_q;
  logic [2:0] tg_q;
  // a bad command never frees the register, so the next command hangs
  always_ff @(posedge i_ref_clk) o_ext_free <= i_rst_b & ~i_hang;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      n_q <= 6'h00;
      rg_q <= 3'h0;
      o_rx_full <= 1'b0;
      o_rx_char <= 7'h00;
    end else if (i_rx_take) begin
      o_rx_full <= 1'b0;
      o_rx_char <= ~o_rx_char;
      n_q <= n_q + 6'h01;
      rg_q <= 3'h5;
    end else if (rg_q != 3'h0) begin
      rg_q <= rg_q - 3'h1;
    end else if (!o_rx_full) begin
      o_rx_full <= 1'b1;
      o_rx_char <= {1'b1, 6'(n_q * 5 + 1)};
    end
  end
  // slow output device: busy for a while after each character
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || (tg_q == 3'h1)) begin
      o_tx_free <= 1'b1;
      tg_q <= 3'h0;
    end else if (i_tx_start) begin
      o_tx_free <= 1'b0;
      tg_q <= 3'h6;
    end else if (tg_q != 3'h0) begin
      tg_q <= tg_q - 3'h1;
    end
  end
endmodule : periph_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench import cskip_io_pkg::*; ;
  logic i_ref_clk = 1'b0, i_rst_b = 1'b0, i_start = 1'b0, i_repeat = 1'b0, i_step_mode = 1'b0;
  logic i_disconnect = 1'b0, hang = 1'b0, flt, s;
  logic [WORD_W-1:0] i_instr = '0, i_acc = '0, i_mem_rdata = '0, mem = '0, o_mem_wdata, y, a;
  logic [ADDR_W-1:0] i_index_val = '0, o_mem_addr, o_ext_cmd, addr_q, cmd_q;
  logic o_mem_rd, o_mem_wr, o_ext_start, i_ext_free, i_rx_full, o_rx_take, o_tx_start, i_tx_free;
  logic o_busy, o_done, o_skip, o_repeat_stop, o_io_fault;
  logic [CHAR_W-1:0] i_rx_char, o_tx_char;
  logic [CHAR_W-1:0] tx_log[4];
  logic [1:0] o_pc_step;
  logic [2:0] sels[4] = '{3'h0, 3'h4, 3'h3, 3'h6};
  int num_errors = 0, total_checks = 0, wr_n = 0, tx_n = 0, rx_n = 0, cyc, n, k;
  // one cycle per microsecond keeps every least time but the external_function repeat at its documented count
  cskip_io_exec #(.EQ_CYC(T_EQ_US), .EQ_RPT_CYC(T_EQ_RPT_US), .GT_CYC(T_GT_US), .GT_RPT_CYC(T_GT_RPT_US),
    .EXF_CYC(T_EXF_US), .RD_CYC(T_RD_US), .RD_RPT_CYC(T_RD_RPT_US), .RDA_CYC(T_RDA_US),
    .RDA_RPT_CYC(T_RDA_RPT_US), .WR_CYC(T_WR_US), .WR_RPT_CYC(T_WR_RPT_US), .WRA_CYC(T_WRA_US),
    .WRA_RPT_CYC(T_WRA_RPT_US)) cskip_io_exec_inst (.*);
  periph_model periph_model_inst (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_hang(hang),
    .i_rx_take(o_rx_take), .i_tx_start(o_tx_start), .o_ext_free(i_ext_free), .o_rx_full(i_rx_full),
    .o_rx_char(i_rx_char), .o_tx_free(i_tx_free));
  always #2 i_ref_clk = ~i_ref_clk;
  // ==========================================
  // storage model and trace capture
  always @(posedge i_ref_clk) begin
    i_mem_rdata <= o_mem_rd ? mem : ~i_mem_rdata; // idle bus never repeats the last word
    if (o_mem_rd) addr_q <= o_mem_addr;
    if (o_mem_wr) begin mem <= o_mem_wdata; wr_n <= wr_n + 1; end
    if (o_ext_start) cmd_q <= o_ext_cmd;
    if (o_tx_start) begin tx_log[tx_n[1:0]] <= o_tx_char; tx_n <= tx_n + 1; end
    if (o_rx_take) rx_n <= rx_n + 1;
  end
  function automatic logic [5:0] ch(int i);
    return 6'(i * 5 + 1);
  endfunction : ch
  task chk(string nm, logic [23:0] e, logic [23:0] g);
    total_checks++;
    if (g !== e) begin num_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end
  endtask : chk
  task run(logic [23:0] ins, logic [14:0] ix, logic rpt, logic st);
    @(posedge i_ref_clk);
    i_start <= 1'b1; i_instr <= ins; i_index_val <= ix; i_repeat <= rpt; i_step_mode <= st;
    @(posedge i_ref_clk);
    i_start <= 1'b0;
    cyc = 1;
    do begin @(negedge i_ref_clk); cyc++; end while (o_done !== 1'b1 && cyc < 3000);
    flt = o_io_fault;
    chk("done", 1, cyc < 3000);
  endtask : run
  task stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  initial begin repeat (60000) @(posedge i_ref_clk); num_errors++; stop_test; end
  // ==========================================
  // tests
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    i_acc <= 24'h000100;
    for (int op = 0; op < 4; op++) for (int j = 0; j < 3; j++) begin
      mem = (j == 0) ? 24'h000100 : (j == 1) ? 24'h000200 : 24'h000080;
      s = (op == 0) ? j == 0 : (op == 1) ? j != 0 : (op == 2) ? j != 1 : j == 1;
      run({OP_EQUAL_SKIP + 6'(op), 3'h0, 15'h0123}, 15'h7ffe, op[0], 1'b0);
      chk("skip", s, o_skip);
      chk("pc_step", s ? 24'h2 : 24'h1, o_pc_step);
      chk("rpt_stop", s & op[0], o_repeat_stop);
      chk("addr", 24'h000121, addr_q);
      n = (op < 2) ? (op[0] ? T_EQ_RPT_US : T_EQ_US) : (op[0] ? T_GT_RPT_US : T_GT_US);
      chk("time", 1, cyc >= n && cyc < n + 8);
    end
    i_acc <= 24'hff0010; mem = 24'h000010;
    run({OP_EQUAL_SKIP, 3'h1, 15'h0005}, 15'h0000, 1'b0, 1'b0);
    chk("skip_sel1", 1, o_skip);
    i_acc <= 24'h800001; mem = 24'h000002;
    run({OP_GREATER_SKIP, 3'h4, 15'h0005}, 15'h0000, 1'b0, 1'b0);
    chk("skip_sel4", 0, o_skip);
    $display("test compare done");
    run({OP_EXTERNAL_FUNCTION, 3'h5, 15'h7fff}, 15'h0002, 1'b0, 1'b0);
    chk("ext_cmd", 24'h000001, cmd_q);
    chk("ext_time", 1, cyc >= T_EXF_US);
    $display("test command done");
    for (int t = 0; t < 3; t++) begin
      n = rx_n; y = 24'habcdef; mem = y;
      run({OP_READ_FROM_DEVICE, (t == 0) ? 3'h0 : (t == 1) ? 3'h4 : 3'h2, 15'h0010}, 15'h0000, 1'b0, 1'b0);
      a = {ch(n), ch(n + 1), ch(n + 2), ch(n + 3)};
      if (t == 1) a = {y[23:15], a[14:0]};
      if (t == 2) begin a = y; a[14:8] = {1'b1, ch(n)}; end
      chk("rd_word", a, mem);
      chk("rd_time", 1, cyc >= ((t == 2) ? T_RD_US : T_RDA_US));
    end
    y = 24'h5a5a5a; mem = y; k = wr_n;
    fork
      run({OP_READ_FROM_DEVICE, 3'h0, 15'h0010}, 15'h0000, 1'b0, 1'b0);
      begin repeat (12) @(posedge i_ref_clk); i_disconnect <= 1'b1; end
    join
    i_disconnect <= 1'b0;
    chk("disc_word", y, mem);
    chk("disc_wr", k, wr_n);
    $display("test input done");
    for (int t = 0; t < 4; t++) begin
      y = 24'h9c3a65; mem = y; tx_n = 0;
      run({OP_WRITE_TO_DEVICE, sels[t], 15'h0040}, 15'h0000, 1'b0, 1'b0);
      a = (t == 0) ? y : {9'h000, y[14:0]};
      if (t < 2) for (int c = 0; c < 4; c++) chk("tx_char", {1'b0, a[23 - 6 * c -: 6]}, tx_log[c]);
      else chk("tx_char", (t == 2) ? y[22:16] : y[14:8], tx_log[0]);
      chk("tx_count", (t < 2) ? 4 : 1, tx_n);
    end
    $display("test output done");
    for (int t = 0; t < 2; t++) begin
      k = wr_n;
      run({OP_READ_FROM_DEVICE + 6'(t), 3'h2, 15'h0010}, 15'h0000, 1'b0, 1'b1);
      chk("fault", 1, flt);
      chk("fault_wr", k, wr_n);
    end
    $display("test step done");
    hang <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    i_start <= 1'b1; i_instr <= {OP_EXTERNAL_FUNCTION, 3'h0, 15'h0007};
    @(posedge i_ref_clk);
    i_start <= 1'b0; s = 1'b0;
    repeat (300) begin @(negedge i_ref_clk); if (o_done === 1'b1) s = 1'b1; end
    chk("hang", 1, o_busy === 1'b1 && !s);
    $display("test hang done");
    stop_test;
  end
endmodule : testbench
